// ---- hw/msps_sequencer.sv ----
// Purpose: Conversion sequencing, averaging, refresh, port logic.
// Assumes: Converter result settles within each slot.
// Notes:   Configuration arrives as plain ports.
//
// Functional notes
// - Four sample rates, 200k after reset.
// - Input range held per port.
// - Single sweep converts all ascending; idle default.
// - Single conversion converts one, then advances.
// - Continuous sweep loops and ignores trigger.
// - Averaging blocks 1..128, write when complete.
// - Averaging change clears that port's result.
// - Active mode change clears; idle keeps results.
// - Single-ended, differential or pseudo inputs.
// - Single-ended unsigned, paired two's complement.
// - Converter reference per port, driver global.
// - Driver refresh 40us per output port.
// - Jump mode refreshes written port, continues.
// - Ports may use either shared preset.
// - Overcurrent raises event and per-port status.
// - Input threshold code from port's data.
// - Input edge detect: rise, fall, both, none.
// - Output level from data, state from host.
// - Translator passes one input to chosen outputs.
// - Bidirectional pairs adjacent within one group.
// - Monitoring mode samples output port too.
// - Complete event per conversion or per sweep.
`timescale 1ns/1ps
`default_nettype none

module msps_sequencer (
  input wire logic mclk,
  input wire logic rstn,
  input wire msps_pkg::msps_adc_mode_t adcMode,
  input wire msps_pkg::msps_rate_t convRate,
  input wire logic convert_trigger_n,
  input wire logic convertRequest,
  input wire msps_pkg::msps_func_t portFunc [msps_pkg::NPORT],
  input wire msps_pkg::msps_input_t inputKind [msps_pkg::NPORT],
  input wire msps_pkg::msps_port_t negPort [msps_pkg::NPORT],
  input wire logic [1:0] adcRange [msps_pkg::NPORT],
  input wire logic [msps_pkg::NPORT-1:0] adcRefDac,
  input wire logic [2:0] avgLog [msps_pkg::NPORT],
  input wire msps_pkg::msps_code_t adcRaw,
  output logic adcStart,
  output msps_pkg::msps_port_t adcPosSel,
  output msps_pkg::msps_port_t adcNegSel,
  output logic adcNegGround,
  output logic [1:0] adcRangeSel,
  output logic adcRefSel,
  output msps_pkg::msps_code_t adcResult [msps_pkg::NPORT],
  output logic [msps_pkg::NPORT-1:0] adcDataReady,
  output logic conversion_complete_event,
  input wire msps_pkg::msps_code_t dacData [msps_pkg::NPORT],
  input wire msps_pkg::msps_src_t dacSource [msps_pkg::NPORT],
  input wire msps_pkg::msps_code_t preset1,
  input wire msps_pkg::msps_code_t preset2,
  input wire logic [msps_pkg::NPORT-1:0] dacWriteStrobe,
  input wire logic dacJumpEn,
  input wire logic dacRefExt,
  output msps_pkg::msps_port_t dacPortSel,
  output msps_pkg::msps_code_t dacCode,
  output logic dacLoad,
  output logic dacRefExtSel,
  input wire logic [msps_pkg::NPORT-1:0] overcurrent,
  input wire logic [msps_pkg::NPORT-1:0] overcurrentClear,
  output logic [msps_pkg::NPORT-1:0] overcurrentStatus,
  output logic overcurrentEvent,
  input wire logic [msps_pkg::NPORT-1:0] general_input_port,
  input wire msps_pkg::msps_edge_t gpiEdge [msps_pkg::NPORT],
  input wire logic [msps_pkg::NPORT-1:0] gpiEventClear,
  output logic [msps_pkg::NPORT-1:0] gpiEventStatus,
  output logic gpiEvent,
  input wire logic [msps_pkg::NPORT-1:0] gpoState,
  output logic [msps_pkg::NPORT-1:0] general_output_port,
  input wire logic uniEnable,
  input wire msps_pkg::msps_port_t uniSrcPort,
  input wire logic [msps_pkg::NPORT-1:0] uniDestMask,
  input wire logic [msps_pkg::NPORT-2:0] bidirRequest,
  output logic [msps_pkg::NPORT-2:0] bidirPairActive
);
  import msps_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstSyncN;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  // ----------------------------------------------------------------
  // Port walks
  // ----------------------------------------------------------------
  msps_scan_if adcScan ();
  msps_scan_if dacScan ();
  msps_port_t convIdx;
  msps_port_t dacIdx;
  logic [NPORT-1:0] adcMask;
  logic [NPORT-1:0] dacMask;

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      adcMask[i] = portFunc[i] == FUNC_ADC ||
                   portFunc[i] == FUNC_DAC_MON;
      dacMask[i] = portFunc[i] != FUNC_HIZ && portFunc[i] != FUNC_ADC;
    end
  end

  assign adcScan.mask = adcMask;
  assign adcScan.cur = convIdx;
  assign dacScan.mask = dacMask;
  assign dacScan.cur = dacIdx;

  msps_port_scan adcFinder (.scan(adcScan));
  msps_port_scan dacFinder (.scan(dacScan));

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  // One pulse per low period, when the minimum width is
  // reached, so a long low does not retrigger.
  logic [TRIG_W-1:0] lowCnt;
  logic trigger;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lowCnt <= '0;
    end else if (convert_trigger_n) begin
      lowCnt <= '0;
    end else if (lowCnt != TRIG_MIN_CYC) begin
      lowCnt <= lowCnt + 1'b1;
    end
  end
  assign trigger = convertRequest ||
    (!convert_trigger_n && lowCnt == TRIG_MIN_CYC - 1'b1);

  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  msps_adc_mode_t lastActive;
  logic modeClear;

  assign modeClear = adcMode != ADC_IDLE && adcMode != lastActive;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lastActive <= ADC_IDLE;
    end else if (adcMode != ADC_IDLE) begin
      lastActive <= adcMode;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  msps_adc_state_t adcState;
  logic [SLOT_W-1:0] slotCnt;
  logic [SLOT_W-1:0] slotLen;
  logic startNow;
  msps_port_t startIdx;

  always_comb begin
    unique case (convRate)
      RATE_400K: slotLen = RATE0_CYC;
      RATE_333K: slotLen = RATE1_CYC;
      RATE_250K: slotLen = RATE2_CYC;
      RATE_200K: slotLen = RATE3_CYC;
    endcase
  end

  always_comb begin
    startNow = 1'b0;
    startIdx = adcScan.first;
    if (adcScan.any && !modeClear) begin
      if (adcState == ST_WAIT) begin
        unique case (adcMode)
          ADC_IDLE: startNow = 1'b0;
          ADC_SINGLE_SWEEP: startNow = trigger;
          ADC_SINGLE_CONV: begin
            startNow = trigger;
            startIdx = adcMask[convIdx] ? convIdx : adcScan.next;
          end
          ADC_CONT_SWEEP: startNow = 1'b1;
        endcase
      end else if (adcState == ST_STORE) begin
        startIdx = adcScan.next;
        startNow = adcMode == ADC_CONT_SWEEP ||
          (adcMode == ADC_SINGLE_SWEEP && !adcScan.wrap);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      adcState <= ST_WAIT;
      slotCnt <= '0;
      convIdx <= '0;
    end else if (modeClear) begin
      adcState <= ST_WAIT;
      slotCnt <= '0;
    end else begin
      unique case (adcState)
        ST_WAIT: begin
          if (startNow) begin
            adcState <= ST_CONV;
            convIdx <= startIdx;
          end
        end
        ST_CONV: begin
          if (slotCnt == slotLen - 1'b1) begin
            adcState <= ST_STORE;
            slotCnt <= '0;
          end else begin
            slotCnt <= slotCnt + 1'b1;
          end
        end
        ST_STORE: begin
          convIdx <= adcScan.next;
          adcState <= startNow ? ST_CONV : ST_WAIT;
        end
        default: adcState <= ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      conversion_complete_event <= 1'b0;
    end else begin
      conversion_complete_event <= adcState == ST_STORE && !modeClear &&
        (adcMode == ADC_SINGLE_CONV || adcScan.wrap);
    end
  end

  // Selection is latched as a slot opens, held through it.
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      adcStart <= 1'b0;
      adcPosSel <= '0;
      adcNegSel <= '0;
      adcNegGround <= 1'b1;
      adcRangeSel <= 2'h0;
      adcRefSel <= 1'b0;
    end else begin
      adcStart <= startNow;
      if (startNow) begin
        adcPosSel <= startIdx;
        adcNegSel <= negPort[startIdx];
        adcNegGround <= inputKind[startIdx] == IN_SINGLE;
        adcRangeSel <= adcRange[startIdx];
        adcRefSel <= adcRefDac[startIdx];
      end
    end
  end

  // ----------------------------------------------------------------
  // Averaging and results
  // ----------------------------------------------------------------
  logic [SUM_W-1:0] accSum [NPORT];
  logic [CNT_W-1:0] accCnt [NPORT];
  logic [AVG_LOG_W-1:0] prevAvg [NPORT];
  logic [SUM_W-1:0] sumNext;
  logic [CNT_W-1:0] cntNext;
  logic [SUM_W-1:0] avgWide;
  msps_code_t avgCode;

  always_comb begin
    sumNext = accSum[convIdx] + SUM_W'(adcRaw);
    cntNext = accCnt[convIdx] + 1'b1;
    avgWide = sumNext >> avgLog[convIdx];
    avgCode = avgWide[CODE_W-1:0];
    // Raw codes are offset binary; a flipped top bit gives
    // two's complement.
    if (inputKind[convIdx] != IN_SINGLE) begin
      avgCode[CODE_W-1] = ~avgCode[CODE_W-1];
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      adcDataReady <= '0;
      for (int i = 0; i < NPORT; i++) begin
        accSum[i] <= '0;
        accCnt[i] <= '0;
        prevAvg[i] <= '0;
        adcResult[i] <= CODE_ZERO;
      end
    end else begin
      adcDataReady <= '0;
      for (int i = 0; i < NPORT; i++) begin
        prevAvg[i] <= avgLog[i];
        if (modeClear || prevAvg[i] != avgLog[i]) begin
          adcResult[i] <= CODE_ZERO;
          accSum[i] <= '0;
          accCnt[i] <= '0;
        end else if (adcState == ST_STORE && convIdx == PORT_W'(i)) begin
          if (cntNext == CNT_W'(1) << avgLog[i]) begin
            adcResult[i] <= avgCode;
            adcDataReady[i] <= 1'b1;
            accSum[i] <= '0;
            accCnt[i] <= '0;
          end else begin
            accSum[i] <= sumNext;
            accCnt[i] <= cntNext;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output driver refresh
  // ----------------------------------------------------------------
  logic [DSLOT_W-1:0] dacCnt;
  logic dacBusy;
  logic jumpReq;
  msps_port_t jumpIdx;
  logic [NPORT-1:0] jumpMask;

  assign jumpMask = dacWriteStrobe & dacMask;

  always_comb begin
    jumpIdx = '0;
    for (int i = NPORT - 1; i >= 0; i--) begin
      if (jumpMask[i]) begin
        jumpIdx = PORT_W'(i);
      end
    end
    jumpReq = dacJumpEn && |jumpMask;
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      dacIdx <= '0;
      dacCnt <= '0;
      dacBusy <= 1'b0;
      dacLoad <= 1'b0;
    end else begin
      dacLoad <= 1'b0;
      if (!dacScan.any) begin
        dacBusy <= 1'b0;
        dacCnt <= '0;
      end else if (jumpReq) begin
        dacIdx <= jumpIdx;
        dacCnt <= '0;
        dacBusy <= 1'b1;
        dacLoad <= 1'b1;
      end else if (!dacBusy || dacCnt == DAC_SLOT_CYC - 1'b1) begin
        dacIdx <= dacBusy ? dacScan.next : dacScan.first;
        dacCnt <= '0;
        dacBusy <= 1'b1;
        dacLoad <= 1'b1;
      end else begin
        dacCnt <= dacCnt + 1'b1;
      end
    end
  end

  // The code tracks the slot's port each cycle, so a write
  // lands without waiting for the next visit.
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      dacCode <= CODE_ZERO;
      dacPortSel <= '0;
      dacRefExtSel <= 1'b0;
    end else begin
      dacPortSel <= dacIdx;
      dacRefExtSel <= dacRefExt;
      unique case (dacSource[dacIdx])
        SRC_PRESET1: dacCode <= preset1;
        SRC_PRESET2: dacCode <= preset2;
        default: dacCode <= dacData[dacIdx];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent reporting
  // ----------------------------------------------------------------
  logic [NPORT-1:0] ocPrev;
  logic [NPORT-1:0] ocRise;

  assign ocRise = overcurrent & ~ocPrev;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ocPrev <= '0;
      overcurrentStatus <= '0;
      overcurrentEvent <= 1'b0;
    end else begin
      ocPrev <= overcurrent;
      overcurrentStatus <= (overcurrentStatus & ~overcurrentClear) |
                           overcurrent;
      overcurrentEvent <= |ocRise;
    end
  end

  // ----------------------------------------------------------------
  // General input edges
  // ----------------------------------------------------------------
  logic [NPORT-1:0] gpiPrev;
  logic [NPORT-1:0] gpiHit;

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      gpiHit[i] = portFunc[i] == FUNC_GPI && (
        (gpiEdge[i] == EDGE_RISE && general_input_port[i] && !gpiPrev[i]) ||
        (gpiEdge[i] == EDGE_FALL && !general_input_port[i] && gpiPrev[i]) ||
        (gpiEdge[i] == EDGE_BOTH && general_input_port[i] != gpiPrev[i]));
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      gpiPrev <= '0;
      gpiEventStatus <= '0;
      gpiEvent <= 1'b0;
    end else begin
      gpiPrev <= general_input_port;
      gpiEventStatus <= (gpiEventStatus & ~gpiEventClear) | gpiHit;
      gpiEvent <= |gpiHit;
    end
  end

  // ----------------------------------------------------------------
  // General outputs and translators
  // ----------------------------------------------------------------
  logic uniLive;

  assign uniLive = uniEnable && portFunc[uniSrcPort] == FUNC_GPI;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      general_output_port <= '0;
      bidirPairActive <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (portFunc[i] != FUNC_GPO) begin
          general_output_port[i] <= 1'b0;
        end else if (uniLive && uniDestMask[i]) begin
          general_output_port[i] <= general_input_port[uniSrcPort];
        end else begin
          general_output_port[i] <= gpoState[i];
        end
      end
      bidirPairActive <= bidirRequest & BIDIR_LEGAL;
    end
  end

endmodule // msps_sequencer

`default_nettype wire

// ---- hw/msps_pkg.sv ----
// Purpose: Constants and types for the port sequencer.
// Assumes: 25 MHz mclk; twelve ports; 12-bit converter codes.
// Notes:   Encodings are local to this design.

package msps_pkg;

  localparam int NPORT = 12;
  localparam int PORT_W = 4;
  localparam int CODE_W = 12;
  localparam int GROUP_SIZE = 6;

  typedef logic [PORT_W-1:0] msps_port_t;
  typedef logic [CODE_W-1:0] msps_code_t;

  // ----------------------------------------------------------------
  // Modes and per-port settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADC_IDLE = 2'h0,
    ADC_SINGLE_SWEEP = 2'h1,
    ADC_SINGLE_CONV = 2'h2,
    ADC_CONT_SWEEP = 2'h3
  } msps_adc_mode_t;

  typedef enum logic [1:0] {
    RATE_400K = 2'h0,
    RATE_333K = 2'h1,
    RATE_250K = 2'h2,
    RATE_200K = 2'h3
  } msps_rate_t;

  typedef enum logic [2:0] {
    FUNC_HIZ = 3'h0,
    FUNC_ADC = 3'h1,
    FUNC_DAC = 3'h2,
    FUNC_DAC_MON = 3'h3,
    FUNC_GPI = 3'h4,
    FUNC_GPO = 3'h5
  } msps_func_t;

  typedef enum logic [1:0] {
    IN_SINGLE = 2'h0,
    IN_DIFF = 2'h1,
    IN_PSEUDO = 2'h2
  } msps_input_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } msps_edge_t;

  typedef enum logic [1:0] {
    SRC_OWN = 2'h0,
    SRC_PRESET1 = 2'h1,
    SRC_PRESET2 = 2'h2
  } msps_src_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_CONV = 2'h1,
    ST_STORE = 2'h3
  } msps_adc_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_KHZ = 25000;
  localparam int MCLK_PERIOD_NS = 40;
  localparam int RATE0_KSPS = 400;
  localparam int RATE1_KSPS = 333;
  localparam int RATE2_KSPS = 250;
  localparam int RATE3_KSPS = 200;
  localparam int SLOT_W = 7;
  localparam logic [SLOT_W-1:0] RATE0_CYC = SLOT_W'(MCLK_KHZ / RATE0_KSPS);
  localparam logic [SLOT_W-1:0] RATE1_CYC = SLOT_W'(MCLK_KHZ / RATE1_KSPS);
  localparam logic [SLOT_W-1:0] RATE2_CYC = SLOT_W'(MCLK_KHZ / RATE2_KSPS);
  localparam logic [SLOT_W-1:0] RATE3_CYC = SLOT_W'(MCLK_KHZ / RATE3_KSPS);
  localparam int TRIG_MIN_NS = 500;
  localparam int TRIG_W = 4;
  localparam logic [TRIG_W-1:0] TRIG_MIN_CYC =
    TRIG_W'((TRIG_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam int DAC_SLOT_US = 40;
  localparam int DSLOT_W = 10;
  localparam logic [DSLOT_W-1:0] DAC_SLOT_CYC =
    DSLOT_W'(DAC_SLOT_US * 1000 / MCLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Averaging, reset values, pair legality
  // ----------------------------------------------------------------
  localparam int AVG_LOG_W = 3;
  localparam int SUM_W = CODE_W + 7;
  localparam int CNT_W = 8;
  localparam msps_code_t CODE_ZERO = 12'h000;
  // Bit i pairs port i with i+1; bit 5 would cross groups.
  localparam logic [NPORT-2:0] BIDIR_LEGAL = 11'h7df;

endpackage

// ---- hw/msps_scan_if.sv ----
// Purpose: Port mask and position for the next-port finder.
// Assumes: Combinational, one clock domain.
// Notes:   One instance per port walk.
`timescale 1ns/1ps
`default_nettype none

interface msps_scan_if;
  import msps_pkg::*;
  logic [NPORT-1:0] mask;
  msps_port_t cur;
  msps_port_t next;
  msps_port_t first;
  logic any;
  logic wrap;
  modport finder (input mask, cur, output next, first, any, wrap);
  modport user (output mask, cur, input next, first, any, wrap);
endinterface

`default_nettype wire

// ---- hw/msps_port_scan.sv ----
// Purpose: Finds the next enabled port, wrapping round.
// Assumes: mask bit i set means port i takes part in the walk.
// Notes:   wrap flags no enabled port above cur.
`timescale 1ns/1ps
`default_nettype none

module msps_port_scan (
  msps_scan_if.finder scan
);
  import msps_pkg::*;

  logic higher;

  always_comb begin
    scan.first = '0;
    scan.next = '0;
    higher = 1'b0;
    // Walking down lets the lowest index win.
    for (int i = NPORT - 1; i >= 0; i--) begin
      if (scan.mask[i]) begin
        scan.first = PORT_W'(i);
        if (PORT_W'(i) > scan.cur) begin
          scan.next = PORT_W'(i);
          higher = 1'b1;
        end
      end
    end
    if (!higher) begin
      scan.next = scan.first;
    end
    scan.any = |scan.mask;
    scan.wrap = !higher;
  end

endmodule // msps_port_scan

`default_nettype wire

// ---- bench/msps_seq_assertions.sv ----
// Purpose: Port-level checks.
// Assumes: Bound by wildcard names.
// Notes: Selects are judged as a slot opens.
`timescale 1ns/1ps
`default_nettype none
module msps_seq_assertions
  import msps_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire msps_adc_mode_t adcMode,
  input wire msps_input_t inputKind [NPORT],
  input wire logic [1:0] adcRange [NPORT],
  input wire logic [NPORT-1:0] adcRefDac,
  input wire logic adcStart,
  input wire msps_port_t adcPosSel,
  input wire logic adcNegGround,
  input wire logic [1:0] adcRangeSel,
  input wire logic adcRefSel,
  input wire logic dacLoad,
  input wire logic dacJumpEn,
  input wire logic [NPORT-2:0] bidirRequest,
  input wire logic [NPORT-2:0] bidirPairActive,
  input wire logic [NPORT-1:0] overcurrent,
  input wire logic [NPORT-1:0] overcurrentStatus,
  input wire logic overcurrentEvent,
  input wire logic conversion_complete_event
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic [10:0] gap;
  logic seen;
  // The first load has no predecessor to time from.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else begin
      gap <= dacLoad ? 11'h001 : gap + 11'h001;
      seen <= seen | dacLoad;
    end
  end
  AST_DAC_SLOT: assert property (
    dacLoad && seen && !dacJumpEn |-> gap == 11'h3e8)
    else $error("slot length wrong");
  AST_IDLE_QUIET: assert property (
    adcMode == ADC_IDLE && $past(adcMode) == ADC_IDLE |-> !adcStart)
    else $error("start in idle");
  AST_CONT_RUNS: assert property (
    (adcMode == ADC_CONT_SWEEP) [*2] |-> ##[0:130] adcStart)
    else $error("sweep stalled");
  AST_NEG_GROUND: assert property (
    adcStart |-> adcNegGround == (inputKind[adcPosSel] == IN_SINGLE))
    else $error("neg input wrong");
  AST_RANGE_HELD: assert property (
    adcStart |-> adcRangeSel == adcRange[adcPosSel] ##1
    $stable(adcRangeSel) [*3])
    else $error("range select wrong");
  AST_REF_PORT: assert property (
    adcStart |-> adcRefSel == adcRefDac[adcPosSel])
    else $error("reference select wrong");
  AST_BIDIR_PAIR: assert property (
    1'b1 |=> bidirPairActive == ($past(bidirRequest) & 11'h7df))
    else $error("pair legality wrong");
  AST_OVC_FLAG: assert property (
    |(overcurrent & ~$past(overcurrent)) |=> overcurrentEvent &&
    (overcurrentStatus & $past(overcurrent)) == $past(overcurrent))
    else $error("overcurrent missed");
  cover property (conversion_complete_event);
  cover property (adcStart && !adcNegGround);
  cover property (overcurrentEvent);
endmodule // msps_seq_assertions
`default_nettype wire

// ---- bench/msps_adc_model.sv ----
// Purpose: Converter front end, one raw code per slot.
// Assumes: Code sampled before the next slot.
// Notes: Code is port index over a fixed pattern.
`timescale 1ns/1ps
`default_nettype none
module msps_adc_model (
  input wire logic mclk,
  input wire logic adcStart,
  input wire msps_pkg::msps_port_t adcPosSel,
  output msps_pkg::msps_code_t adcRaw
);
  initial adcRaw = 12'h000;
  always @(posedge mclk) begin
    if (adcStart) adcRaw <= {adcPosSel, 8'ha5};
  end
endmodule // msps_adc_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Bench for the port sequencer.
// Assumes: Inputs change on the falling edge of mclk.
// Notes: Results are matched from queues.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msps_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, convert_trigger_n = 1'b1;
  logic convertRequest = 1'b0, dacJumpEn = 1'b0, dacRefExt = 1'b0;
  logic uniEnable = 1'b0, strictMon = 1'b1, dl = 1'b0;
  msps_adc_mode_t adcMode = ADC_IDLE;
  msps_rate_t convRate = RATE_200K;
  msps_func_t portFunc [NPORT] = '{default: FUNC_HIZ};
  msps_input_t inputKind [NPORT] = '{default: IN_SINGLE};
  msps_port_t negPort [NPORT] = '{default: 4'h0};
  msps_port_t uniSrcPort = 4'h0, adcPosSel, adcNegSel, dacPortSel;
  logic [1:0] adcRange [NPORT] = '{default: 2'h0}, adcRangeSel;
  logic [2:0] avgLog [NPORT] = '{default: 3'h0};
  msps_code_t dacData [NPORT] = '{default: 12'h000};
  msps_src_t dacSource [NPORT] = '{default: SRC_OWN};
  msps_edge_t gpiEdge [NPORT] = '{default: EDGE_NONE};
  msps_code_t preset1 = 12'h000, preset2 = 12'h000;
  msps_code_t adcRaw, dacCode, adcResult [NPORT];
  logic [NPORT-1:0] adcRefDac = '0, dacWriteStrobe = '0, overcurrent = '0;
  logic [NPORT-1:0] overcurrentClear = '0, general_input_port = '0;
  logic [NPORT-1:0] gpiEventClear = '0, gpoState = '0, uniDestMask = '0;
  logic [NPORT-1:0] adcDataReady, overcurrentStatus, gpiEventStatus;
  logic [NPORT-1:0] general_output_port;
  logic [NPORT-2:0] bidirRequest = '0, bidirPairActive;
  logic adcStart, adcNegGround, adcRefSel, conversion_complete_event;
  logic dacLoad, dacRefExtSel, overcurrentEvent, gpiEvent;
  logic [15:0] q [$], dq [$];
  int n_errors = 0, total_checks = 0, nStart = 0, nEvt = 0;
  msps_sequencer uut (.*);
  msps_adc_model adcm (.mclk, .adcStart, .adcPosSel, .adcRaw);
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic drain();
    for (int i = 0; i < 4000 && q.size() + dq.size() > 0; i++) cyc(1);
    chk(16'(q.size() + dq.size()), 16'h0);
  endtask
  task automatic trig(input int n);
    convert_trigger_n = 1'b0;
    cyc(n);
    convert_trigger_n = 1'b1;
  endtask
  task automatic pulse();
    convertRequest = 1'b1;
    cyc(1);
    convertRequest = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Refresh output lands a cycle after its load.
  always @(negedge mclk) begin
    if (adcStart === 1'b1) nStart++;
    if (conversion_complete_event === 1'b1) nEvt++;
    if (dl && dq.size() > 0) chk({dacPortSel, dacCode}, dq.pop_front());
    dl = dacLoad === 1'b1;
    for (int p = 0; p < NPORT; p++) begin
      if (adcDataReady[p] === 1'b1) begin
        if (q.size() > 0) chk({4'(p), adcResult[p]}, q.pop_front());
        else if (strictMon) chk(16'h0, 16'hffff);
      end
    end
  end
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(81435));
    cyc(10);
    chk({13'h0, adcNegGround, dacLoad, adcStart}, 16'h4);
    cyc(10);
    rstn = 1'b1;
    cyc(4);
    portFunc[2] = FUNC_ADC;
    portFunc[5] = FUNC_ADC;
    portFunc[9] = FUNC_ADC;
    inputKind[5] = IN_DIFF;
    inputKind[9] = IN_PSEUDO;
    negPort[5] = 4'h7;
    adcRange[9] = 2'h2;
    adcRefDac = 12'h200;
    adcMode = ADC_SINGLE_SWEEP;
    trig(12);
    cyc(20);
    chk(16'(nStart), 16'h0);
    q = '{16'h22a5, 16'h5da5, 16'h91a5};
    trig(14);
    drain();
    chk(16'(nEvt), 16'h1);
    $display("sweep test done");
    adcMode = ADC_IDLE;
    cyc(3);
    chk({4'h2, adcResult[2]}, 16'h22a5);
    portFunc[5] = FUNC_HIZ;
    portFunc[9] = FUNC_HIZ;
    adcMode = ADC_SINGLE_CONV;
    cyc(3);
    chk({4'h2, adcResult[2]}, 16'h2000);
    q = '{16'h22a5};
    pulse();
    drain();
    chk(16'(nStart), 16'h4);
    chk(16'(nEvt), 16'h2);
    avgLog[2] = 3'h1;
    cyc(3);
    chk({4'h2, adcResult[2]}, 16'h2000);
    pulse();
    cyc(200);
    q = '{16'h22a5};
    pulse();
    drain();
    $display("conv test done");
    avgLog[2] = 3'h0;
    portFunc[9] = FUNC_ADC;
    q = '{16'h22a5, 16'h91a5, 16'h22a5, 16'h91a5};
    convert_trigger_n = 1'b0;
    adcMode = ADC_CONT_SWEEP;
    drain();
    strictMon = 1'b0;
    adcMode = ADC_IDLE;
    convert_trigger_n = 1'b1;
    cyc(300);
    strictMon = 1'b1;
    $display("cont test done");
    dacData[0] = 12'($urandom);
    preset2 = 12'($urandom) | 12'h001;
    dacSource[4] = SRC_PRESET2;
    dq = '{{4'h0, dacData[0]}, {4'h4, preset2}, {4'h0, dacData[0]}};
    portFunc[0] = FUNC_DAC;
    portFunc[4] = FUNC_DAC;
    drain();
    dacRefExt = 1'b1;
    portFunc[8] = FUNC_DAC;
    dacData[8] = 12'($urandom);
    dacJumpEn = 1'b1;
    cyc(100);
    chk(16'(dacRefExtSel), 16'h1);
    dq = '{{4'h8, dacData[8]}, {4'h0, dacData[0]}};
    dacWriteStrobe[8] = 1'b1;
    cyc(1);
    dacWriteStrobe[8] = 1'b0;
    drain();
    dacJumpEn = 1'b0;
    $display("refresh test done");
    portFunc[3] = FUNC_GPI;
    gpiEdge[3] = EDGE_FALL;
    portFunc[6] = FUNC_GPO;
    portFunc[7] = FUNC_GPO;
    gpoState = 12'h040;
    general_input_port[3] = 1'b1;
    cyc(4);
    chk(16'(gpiEventStatus), 16'h0);
    chk(16'(general_output_port), 16'h40);
    general_input_port[3] = 1'b0;
    cyc(4);
    chk(16'(gpiEventStatus), 16'h8);
    uniEnable = 1'b1;
    uniSrcPort = 4'h3;
    uniDestMask = 12'h080;
    general_input_port[3] = 1'b1;
    cyc(4);
    chk(16'(general_output_port), 16'hc0);
    for (int i = 0; i < 16; i++) begin
      bidirRequest = 11'($urandom);
      cyc(2);
      chk(16'(bidirPairActive), 16'(bidirRequest & ~11'h020));
    end
    overcurrent[4] = 1'b1;
    cyc(2);
    chk(16'(overcurrentStatus), 16'h10);
    $display("port test done");
    finish_test();
  end
endmodule // tb
bind msps_sequencer msps_seq_assertions chk_i (.*);
`default_nettype wire
